// File: dac_cfg.svh
// Register map, field positions, reset values and datapath constants
`ifndef DAC_CFG_SVH
`define DAC_CFG_SVH
`define DAC_AW 3
`define DAC_DW 16
`define DAC_OFF_CMD 3'h0
`define DAC_OFF_FLAGS 3'h1
`define DAC_OFF_ACC 3'h2
`define DAC_OFF_DEST 3'h3
`define DAC_OFF_SRC 3'h4
`define DAC_OFF_STAT 3'h5
`define DAC_CMD_OP_MSB 2
`define DAC_CMD_OP_LSB 0
`define DAC_CMD_WIDE 3
`define DAC_CMD_PAIR_MSB 6
`define DAC_CMD_PAIR_LSB 4
`define DAC_STAT_REFUSED 4
`define DAC_FB_CF 0
`define DAC_FB_PF 2
`define DAC_FB_AF 4
`define DAC_FB_ZF 6
`define DAC_FB_SF 7
`define DAC_FB_TF 8
`define DAC_FB_IF 9
`define DAC_FB_DF 10
`define DAC_FB_OF 11
`define DAC_FLAGS_MASK 16'h0fd5
`define DAC_FLAGS_RST 16'h0000
`define DAC_WORD_RST 16'h0000
`define DAC_NIB_MASK 8'h0f
`define DAC_NIB_MAX 4'h9
`define DAC_ADJ_SIX 8'h06
`define DAC_TEN 8'h0a
`endif

// File: dac_pkg.sv
// Operation and operand pairing types of the adjust and add-with-carry slice
package dac_pkg;
	typedef enum logic [2:0] {
		DAC_OP_ADJ_ADD = 3'b000,
		DAC_OP_ADJ_SUB = 3'b001,
		DAC_OP_ADJ_DIV = 3'b010,
		DAC_OP_ADJ_MUL = 3'b011,
		DAC_OP_ADC = 3'b100
	} dac_op_t;
	typedef enum logic [2:0] {
		DAC_PAIR_REG_REG = 3'b000,
		DAC_PAIR_REG_MEM = 3'b001,
		DAC_PAIR_MEM_REG = 3'b010,
		DAC_PAIR_REG_IMM = 3'b011,
		DAC_PAIR_MEM_IMM = 3'b100,
		DAC_PAIR_ACC_IMM = 3'b101
	} dac_pair_t;
endpackage : dac_pkg

// File: dac_dp_if.sv
// Datapath signals between the core, the adjust unit and the flag unit
`timescale 1ns/10ps
`default_nettype none
interface dac_dp_if;
	dac_pkg::dac_op_t op;
	logic [15:0] acc;
	logic af_in;
	logic [15:0] adj_acc;
	logic adj_af;
	logic [15:0] res;
	logic wide;
	logic pf;
	logic sf;
	logic zf;
	modport adj (input op, input acc, input af_in, output adj_acc, output adj_af);
	modport flg (input res, input wide, output pf, output sf, output zf);
	modport core (output op, output acc, output af_in, output res, output wide,
		input adj_acc, input adj_af, input pf, input sf, input zf);
endinterface : dac_dp_if
`default_nettype wire

// File: dac_adjust.sv
// Unpacked decimal adjust unit for the accumulator byte pair
`timescale 1ns/10ps
`default_nettype none
`include "dac_cfg.svh"
module dac_adjust (
	// Datapath
	dac_dp_if.adj dp
);
	import dac_pkg::*;

	function automatic logic nib_over(input logic [7:0] lo, input logic af);
		nib_over = ((lo & `DAC_NIB_MASK) > {4'h0, `DAC_NIB_MAX}) || af;
	endfunction : nib_over

	logic [7:0] lo;
	logic [7:0] hi;
	logic [15:0] prod;

	assign lo = dp.acc[7:0];
	assign hi = dp.acc[15:8];
	assign prod = hi * `DAC_TEN;

	always_comb begin
		dp.adj_acc = dp.acc;
		dp.adj_af = dp.af_in;
		unique case (dp.op)
			DAC_OP_ADJ_ADD: begin
				// Add six and carry into high byte
				if (nib_over(lo, dp.af_in)) begin // [RULE1]
					dp.adj_acc = {hi + 8'h01, (lo + `DAC_ADJ_SIX) & `DAC_NIB_MASK};
					dp.adj_af = 1'b1;
				end else begin
					dp.adj_acc = {hi, lo & `DAC_NIB_MASK};
					dp.adj_af = 1'b0;
				end
			end
			DAC_OP_ADJ_SUB: begin
				// Subtract six and borrow from high byte
				if (nib_over(lo, dp.af_in)) begin // [RULE2]
					dp.adj_acc = {hi - 8'h01, (lo - `DAC_ADJ_SIX) & `DAC_NIB_MASK};
					dp.adj_af = 1'b1;
				end else begin
					dp.adj_acc = {hi, lo & `DAC_NIB_MASK};
					dp.adj_af = 1'b0;
				end
			end
			DAC_OP_ADJ_DIV: begin
				dp.adj_acc = {8'h00, prod[7:0] + lo}; // [RULE3]
			end
			DAC_OP_ADJ_MUL: begin
				dp.adj_acc = {lo / `DAC_TEN, lo % `DAC_TEN}; // [RULE4]
			end
			default: begin
				dp.adj_acc = dp.acc;
			end
		endcase
	end
endmodule : dac_adjust
`default_nettype wire

// File: dac_flag_calc.sv
// Parity, sign and zero flag generation for byte or word results
`timescale 1ns/10ps
`default_nettype none
module dac_flag_calc (
	// Datapath
	dac_dp_if.flg dp
);
	import dac_pkg::*;

	function automatic logic even_ones(input logic [7:0] v);
		even_ones = ~(^v);
	endfunction : even_ones

	assign dp.pf = even_ones(dp.res[7:0]); // [RULE11]
	assign dp.sf = dp.wide ? dp.res[15] : dp.res[7];
	assign dp.zf = dp.wide ? (dp.res == 16'h0000) : (dp.res[7:0] == 8'h00);
endmodule : dac_flag_calc
`default_nettype wire

// File: dac_alu.sv
// Decimal adjust and add-with-carry datapath slice with register port
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "dac_cfg.svh"
// Behaviour
// RULE1: Adjust after add adds six to a low byte whose low nibble exceeds nine or when aux carry is set, bumps the high byte, sets aux carry, copies it to carry and masks the low byte to its low nibble.
// RULE2: Adjust after subtract does the same with six subtracted and the high byte decremented.
// RULE3: Adjust before divide loads the low byte with high byte times ten plus low byte and clears the high byte.
// RULE4: Adjust after multiply loads the high byte with low byte divided by ten and the low byte with the remainder.
// RULE5: Add-with-carry sums destination and source, byte or word, plus the carry flag, and writes the destination.
// RULE6: Add-with-carry accepts the six register, memory, immediate and accumulator operand pairings.
// RULE7: Add-with-carry treats signed and unsigned alike and updates aux carry, carry, overflow, parity, sign and zero.
// RULE8: Divide and multiply adjusts update parity, sign and zero from the low byte only.
// RULE9: Add and subtract adjusts update only aux carry and carry.
// RULE10: No operation here alters the direction, interrupt enable or single step flags.
// RULE11: Parity is set when the low eight result bits hold an even count of ones.
// RULE12: Add-with-carry aux carry marks a carry out of the low four result bits.
// RULE13: Add-with-carry carry marks a carry out of the operand's top bit.
// RULE14: Flags left undefined by an operation keep their prior values.
module dac_alu (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Register port
	input wire logic [`DAC_AW-1:0] reg_addr,
	input wire logic [`DAC_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`DAC_DW-1:0] reg_rdata,
	// Core status
	output logic [`DAC_DW-1:0] flag_word,
	output dac_pkg::dac_op_t last_op
);
	import dac_pkg::*;

	function automatic logic hit(input logic [`DAC_AW-1:0] a, input logic [`DAC_AW-1:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic pair_legal(input logic [2:0] p);
		pair_legal = (p <= DAC_PAIR_ACC_IMM);
	endfunction : pair_legal

	dac_dp_if dp ();

	logic [15:0] acc_q;
	logic [15:0] acc_d;
	logic [15:0] dest_q;
	logic [15:0] dest_d;
	logic [15:0] src_q;
	logic [15:0] flags_q;
	logic [15:0] flags_d;
	logic refused_q;
	logic last_wide_q;
	dac_op_t last_op_q;
	logic [15:0] rdata_q;

	logic cmd_go;
	logic cmd_ok;
	dac_op_t cmd_op;
	logic cmd_wide;
	logic [2:0] cmd_pair;
	logic to_acc;
	logic cf_in;
	logic [15:0] opd_a;
	logic [16:0] sum_w;
	logic [8:0] sum_b;
	logic [15:0] adc_res;
	logic adc_cf;
	logic adc_af;
	logic adc_of;
	logic a_msb;
	logic b_msb;
	logic r_msb;

	// Command decode
	assign cmd_go = reg_wr && hit(reg_addr, `DAC_OFF_CMD);
	assign cmd_op = dac_op_t'(reg_wdata[`DAC_CMD_OP_MSB:`DAC_CMD_OP_LSB]);
	assign cmd_wide = reg_wdata[`DAC_CMD_WIDE];
	assign cmd_pair = reg_wdata[`DAC_CMD_PAIR_MSB:`DAC_CMD_PAIR_LSB];

	always_comb begin
		unique case (cmd_op)
			DAC_OP_ADJ_ADD, DAC_OP_ADJ_SUB, DAC_OP_ADJ_DIV, DAC_OP_ADJ_MUL: begin
				cmd_ok = 1'b1;
			end
			DAC_OP_ADC: begin
				cmd_ok = pair_legal(cmd_pair); // [RULE6]
			end
			default: begin
				cmd_ok = 1'b0;
			end
		endcase
	end

	// Accumulator pairing writes the accumulator, others the destination
	assign to_acc = (cmd_pair == DAC_PAIR_ACC_IMM); // [RULE6]
	assign opd_a = to_acc ? acc_q : dest_q;
	assign cf_in = flags_q[`DAC_FB_CF];

	// Add with carry, same adder for signed and unsigned
	assign sum_w = {1'b0, opd_a} + {1'b0, src_q} + {16'h0000, cf_in}; // [RULE5] [RULE7]
	assign sum_b = {1'b0, opd_a[7:0]} + {1'b0, src_q[7:0]} + {8'h00, cf_in}; // [RULE5]
	assign adc_res = cmd_wide ? sum_w[15:0] : {opd_a[15:8], sum_b[7:0]};
	assign adc_cf = cmd_wide ? sum_w[16] : sum_b[8]; // [RULE13]
	assign adc_af = opd_a[4] ^ src_q[4] ^ adc_res[4]; // [RULE12]
	assign a_msb = cmd_wide ? opd_a[15] : opd_a[7];
	assign b_msb = cmd_wide ? src_q[15] : src_q[7];
	assign r_msb = cmd_wide ? adc_res[15] : adc_res[7];
	assign adc_of = (a_msb == b_msb) && (r_msb != a_msb); // [RULE7]

	// Shared datapath units
	assign dp.op = cmd_op;
	assign dp.acc = acc_q;
	assign dp.af_in = flags_q[`DAC_FB_AF];
	assign dp.res = (cmd_op == DAC_OP_ADC) ? adc_res : dp.adj_acc;
	assign dp.wide = (cmd_op == DAC_OP_ADC) && cmd_wide;

	dac_adjust u_adjust (
		.dp(dp.adj)
	);

	dac_flag_calc u_flag_calc (
		.dp(dp.flg)
	);

	// Accumulator next value
	always_comb begin
		acc_d = acc_q;
		if (reg_wr && hit(reg_addr, `DAC_OFF_ACC)) begin
			acc_d = reg_wdata;
		end else if (cmd_go && cmd_ok) begin
			if (cmd_op == DAC_OP_ADC) begin
				if (to_acc) begin
					acc_d = adc_res; // [RULE5]
				end
			end else begin
				acc_d = dp.adj_acc; // [RULE1] [RULE2] [RULE3] [RULE4]
			end
		end
	end

	// Destination next value
	always_comb begin
		dest_d = dest_q;
		if (reg_wr && hit(reg_addr, `DAC_OFF_DEST)) begin
			dest_d = reg_wdata;
		end else if (cmd_go && cmd_ok && cmd_op == DAC_OP_ADC && !to_acc) begin
			dest_d = adc_res; // [RULE5]
		end
	end

	// Flag word next value; untouched bits keep prior values
	always_comb begin
		flags_d = flags_q; // [RULE10] [RULE14]
		if (reg_wr && hit(reg_addr, `DAC_OFF_FLAGS)) begin
			flags_d = reg_wdata & `DAC_FLAGS_MASK;
		end else if (cmd_go && cmd_ok) begin
			unique case (cmd_op)
				DAC_OP_ADJ_ADD, DAC_OP_ADJ_SUB: begin
					flags_d[`DAC_FB_AF] = dp.adj_af; // [RULE9]
					flags_d[`DAC_FB_CF] = dp.adj_af; // [RULE1] [RULE2]
				end
				DAC_OP_ADJ_DIV, DAC_OP_ADJ_MUL: begin
					flags_d[`DAC_FB_PF] = dp.pf; // [RULE8]
					flags_d[`DAC_FB_SF] = dp.sf;
					flags_d[`DAC_FB_ZF] = dp.zf;
				end
				DAC_OP_ADC: begin
					flags_d[`DAC_FB_AF] = adc_af; // [RULE7]
					flags_d[`DAC_FB_CF] = adc_cf;
					flags_d[`DAC_FB_OF] = adc_of;
					flags_d[`DAC_FB_PF] = dp.pf;
					flags_d[`DAC_FB_SF] = dp.sf;
					flags_d[`DAC_FB_ZF] = dp.zf;
				end
				default: begin
					flags_d = flags_q;
				end
			endcase
		end
	end

	// Accumulator register
	always_ff @(posedge mclk) begin
		if (reset) begin
			acc_q <= `DAC_WORD_RST;
		end else begin
			acc_q <= acc_d;
		end
	end

	// Destination register
	always_ff @(posedge mclk) begin
		if (reset) begin
			dest_q <= `DAC_WORD_RST;
		end else begin
			dest_q <= dest_d;
		end
	end

	// Source register
	always_ff @(posedge mclk) begin
		if (reset) begin
			src_q <= `DAC_WORD_RST;
		end else if (reg_wr && hit(reg_addr, `DAC_OFF_SRC)) begin
			src_q <= reg_wdata;
		end
	end

	// Flag register
	always_ff @(posedge mclk) begin
		if (reset) begin
			flags_q <= `DAC_FLAGS_RST;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Command status; a refusal wins over a clear
	always_ff @(posedge mclk) begin
		if (reset) begin
			refused_q <= 1'b0;
			last_op_q <= DAC_OP_ADJ_ADD;
			last_wide_q <= 1'b0;
		end else if (cmd_go) begin
			if (cmd_ok) begin
				last_op_q <= cmd_op;
				last_wide_q <= cmd_wide;
			end else begin
				refused_q <= 1'b1;
			end
		end else if (reg_wr && hit(reg_addr, `DAC_OFF_STAT) && reg_wdata[`DAC_STAT_REFUSED]) begin
			refused_q <= 1'b0;
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata_q <= `DAC_WORD_RST;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`DAC_OFF_CMD: rdata_q <= {12'h000, last_wide_q, last_op_q};
				`DAC_OFF_FLAGS: rdata_q <= flags_q;
				`DAC_OFF_ACC: rdata_q <= acc_q;
				`DAC_OFF_DEST: rdata_q <= dest_q;
				`DAC_OFF_SRC: rdata_q <= src_q;
				`DAC_OFF_STAT: rdata_q <= {11'h000, refused_q, 4'h0};
				default: rdata_q <= `DAC_WORD_RST;
			endcase
		end else begin
			rdata_q <= `DAC_WORD_RST;
		end
	end

	assign reg_rdata = rdata_q;
	assign flag_word = flags_q;
	assign last_op = last_op_q;

	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	logic go_ok;
	logic adj_cond;
	logic [4:0] nib_sum;
	assign go_ok = cmd_go && cmd_ok;
	assign adj_cond = ((acc_q[7:0] & `DAC_NIB_MASK) > {4'h0, `DAC_NIB_MAX}) || flags_q[`DAC_FB_AF];
	// Low nibble sum, carry out of the low four bits
	assign nib_sum = {1'b0, opd_a[3:0]} + {1'b0, src_q[3:0]} + {4'h0, cf_in};

	aaa_low_mask_a: assert property ( // [RULE1]
		go_ok && cmd_op == DAC_OP_ADJ_ADD |=> acc_q[7:4] == 4'h0
			&& flags_q[`DAC_FB_CF] == flags_q[`DAC_FB_AF]
			&& flags_q[`DAC_FB_AF] == $past(adj_cond)
			&& acc_q[15:8] == 8'($past(acc_q[15:8]) + {7'h00, $past(adj_cond)}))
		else $error("adjust after add result wrong");

	aas_borrow_a: assert property ( // [RULE2]
		go_ok && cmd_op == DAC_OP_ADJ_SUB |=> acc_q[15:8]
			== 8'($past(acc_q[15:8]) - {7'h00, $past(adj_cond)})
			&& acc_q[7:4] == 4'h0 && flags_q[`DAC_FB_CF] == $past(adj_cond))
		else $error("adjust after subtract result wrong");

	aad_combine_a: assert property ( // [RULE3]
		go_ok && cmd_op == DAC_OP_ADJ_DIV |=> acc_q[15:8] == 8'h00
			&& acc_q[7:0] == 8'($past(acc_q[15:8]) * `DAC_TEN + $past(acc_q[7:0])))
		else $error("adjust before divide result wrong");

	aam_split_a: assert property ( // [RULE4]
		go_ok && cmd_op == DAC_OP_ADJ_MUL |=> acc_q[15:8] == $past(acc_q[7:0]) / `DAC_TEN
			&& acc_q[7:0] == $past(acc_q[7:0]) % `DAC_TEN)
		else $error("adjust after multiply result wrong");

	adc_word_sum_a: assert property ( // [RULE5]
		go_ok && cmd_op == DAC_OP_ADC && cmd_wide && !to_acc |=> dest_q
			== 16'($past(dest_q) + $past(src_q) + {15'h0000, $past(cf_in)})
			&& flags_q[`DAC_FB_CF] == $past(sum_w[16]))
		else $error("add with carry word result wrong");

	adc_byte_keep_a: assert property ( // [RULE13]
		go_ok && cmd_op == DAC_OP_ADC && !cmd_wide && to_acc |=> acc_q[15:8]
			== $past(acc_q[15:8]) && flags_q[`DAC_FB_CF] == $past(sum_b[8]))
		else $error("add with carry byte result wrong");

	ctrl_flags_keep_a: assert property ( // [RULE10]
		cmd_go |=> flags_q[`DAC_FB_DF] == $past(flags_q[`DAC_FB_DF])
			&& flags_q[`DAC_FB_IF] == $past(flags_q[`DAC_FB_IF])
			&& flags_q[`DAC_FB_TF] == $past(flags_q[`DAC_FB_TF]))
		else $error("control flag altered by an operation");

	adj_undef_keep_a: assert property ( // [RULE9]
		go_ok && (cmd_op == DAC_OP_ADJ_ADD || cmd_op == DAC_OP_ADJ_SUB)
			|=> $stable(flags_q[`DAC_FB_ZF]) && $stable(flags_q[`DAC_FB_OF])
			&& $stable(flags_q[`DAC_FB_SF]) && $stable(flags_q[`DAC_FB_PF]))
		else $error("undefined flag changed by add or subtract adjust");

	div_mul_flags_a: assert property ( // [RULE8]
		go_ok && (cmd_op == DAC_OP_ADJ_DIV || cmd_op == DAC_OP_ADJ_MUL)
			|=> flags_q[`DAC_FB_PF] == ~(^acc_q[7:0])
			&& flags_q[`DAC_FB_ZF] == (acc_q[7:0] == 8'h00)
			&& flags_q[`DAC_FB_SF] == acc_q[7] && $stable(flags_q[`DAC_FB_CF]))
		else $error("divide or multiply adjust flags wrong");

	refused_hold_a: assert property ( // [RULE6]
		cmd_go && !cmd_ok |=> refused_q && $stable(acc_q) && $stable(dest_q) && $stable(flags_q))
		else $error("refused command changed state");

	refused_sticky_a: assert property ( // [RULE6]
		refused_q && !(reg_wr && hit(reg_addr, `DAC_OFF_STAT) && reg_wdata[`DAC_STAT_REFUSED])
			|=> refused_q)
		else $error("refused status dropped without a clear");

	adc_aux_nibble_a: assert property ( // [RULE12]
		go_ok && cmd_op == DAC_OP_ADC |=> flags_q[`DAC_FB_AF] == $past(nib_sum[4]))
		else $error("add with carry aux carry wrong");

	read_late_a: assert property (
		reg_rd && hit(reg_addr, `DAC_OFF_ACC) && !reg_wr |=> reg_rdata == $past(acc_q))
		else $error("read data not one cycle after strobe");

	aaa_adjusts_c: cover property (go_ok && cmd_op == DAC_OP_ADJ_ADD && adj_cond);
	adc_carry_c: cover property (go_ok && cmd_op == DAC_OP_ADC && cmd_wide && sum_w[16]);
	aam_nonzero_c: cover property (go_ok && cmd_op == DAC_OP_ADJ_MUL && acc_q[7:0] > `DAC_TEN);
	adc_acc_imm_c: cover property (go_ok && cmd_op == DAC_OP_ADC && to_acc);
endmodule : dac_alu
`default_nettype wire

// File: dac_alu_bench.sv
// Self-checking bench for the decimal adjust and add-with-carry slice
`timescale 1ns/10ps
`default_nettype none
`include "dac_cfg.svh"
module dac_alu_bench;
	import dac_pkg::*;
	typedef struct packed {
		logic [15:0] flags, acc, dest, src, cmd, e_acc, e_dest, e_flags;
	} dac_row_t;
	logic mclk;
	logic reset;
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_rdata;
	logic [15:0] flag_word;
	dac_op_t last_op;
	logic [15:0] v;
	int n_errors;
	int n_checks;
	dac_row_t rows [16];

	dac_alu DUT (
		.mclk(mclk),
		.reset(reset),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.flag_word(flag_word),
		.last_op(last_op)
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic test_done;
		if (n_errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done

	task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk16

	task automatic chk_op(input dac_op_t exp, input dac_op_t got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR last_op expected %h seen %h", exp, got);
		end
	endtask : chk_op

	// Bus cycles start just after an edge and end just after the sampling edge
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		#1;
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		@(posedge mclk);
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic idle;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge mclk);
		#1;
	endtask : idle

	task automatic do_reset;
		reset <= 1'b1;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		#1;
	endtask : do_reset

	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		test_done();
	end

	initial begin
		reset = 1'b1;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		n_errors = 0;
		n_checks = 0;
		// flags, acc, dest, src, cmd, expected acc, dest, flags
		rows = '{
			'{16'h0710, 16'h0109, 16'h1234, 16'h0000, 16'h0000, 16'h020f, 16'h1234, 16'h0711},
			'{16'h0fc4, 16'h000a, 16'h1234, 16'h0000, 16'h0000, 16'h0100, 16'h1234, 16'h0fd5},
			'{16'h0701, 16'h0379, 16'h1234, 16'h0000, 16'h0000, 16'h0309, 16'h1234, 16'h0700},
			'{16'h0010, 16'h0508, 16'h1234, 16'h0000, 16'h0001, 16'h0402, 16'h1234, 16'h0011},
			'{16'h0000, 16'h000f, 16'h1234, 16'h0000, 16'h0001, 16'hff09, 16'h1234, 16'h0011},
			'{16'h0011, 16'h0705, 16'h1234, 16'h0000, 16'h0002, 16'h004b, 16'h1234, 16'h0015},
			'{16'h0840, 16'h1a06, 16'h1234, 16'h0000, 16'h0002, 16'h000a, 16'h1234, 16'h0804},
			'{16'h0080, 16'h0041, 16'h1234, 16'h0000, 16'h0003, 16'h0605, 16'h1234, 16'h0004},
			'{16'h0901, 16'hff00, 16'h1234, 16'h0000, 16'h0003, 16'h0000, 16'h1234, 16'h0945},
			'{16'h0701, 16'h1234, 16'h117f, 16'h2201, 16'h0004, 16'h1234, 16'h1181, 16'h0f94},
			'{16'h0000, 16'h1234, 16'hffff, 16'h0001, 16'h002c, 16'h1234, 16'h0000, 16'h0055},
			'{16'h0001, 16'h7fff, 16'h1111, 16'h0000, 16'h005c, 16'h8000, 16'h1111, 16'h0894},
			'{16'h0000, 16'h1234, 16'h5580, 16'h0080, 16'h0014, 16'h1234, 16'h5500, 16'h0845},
			'{16'h0000, 16'h1234, 16'h5580, 16'h0080, 16'h0034, 16'h1234, 16'h5500, 16'h0845},
			'{16'h0000, 16'h1234, 16'h5580, 16'h0080, 16'h0044, 16'h1234, 16'h5500, 16'h0845},
			'{16'h0001, 16'h12fe, 16'h1111, 16'h0001, 16'h0054, 16'h1200, 16'h1111, 16'h0055}
		};
		do_reset();
		// Ordinary operations, written and read back to back
		foreach (rows[i]) begin
			wr(`DAC_OFF_FLAGS, rows[i].flags);
			wr(`DAC_OFF_ACC, rows[i].acc);
			wr(`DAC_OFF_DEST, rows[i].dest);
			wr(`DAC_OFF_SRC, rows[i].src);
			wr(`DAC_OFF_CMD, rows[i].cmd);
			chk16("flag_word", rows[i].e_flags, flag_word);
			chk_op(dac_op_t'(rows[i].cmd[2:0]), last_op);
			rd(`DAC_OFF_ACC, v);
			chk16("acc", rows[i].e_acc, v);
			rd(`DAC_OFF_DEST, v);
			chk16("dest", rows[i].e_dest, v);
			rd(`DAC_OFF_FLAGS, v);
			chk16("flags", rows[i].e_flags, v);
			rd(`DAC_OFF_CMD, v);
			chk16("cmd", {12'h000, rows[i].cmd[3:0]}, v);
			rd(`DAC_OFF_SRC, v);
			chk16("src", rows[i].src, v);
		end
		idle();
		// Flag register keeps only its defined bits
		wr(`DAC_OFF_FLAGS, 16'hffff);
		rd(`DAC_OFF_FLAGS, v);
		chk16("flags mask", 16'h0fd5, v);
		idle();
		chk16("rdata idle", 16'h0000, reg_rdata);
		// Unmapped places read zero and ignore writes
		wr(`DAC_OFF_ACC, 16'h0123);
		wr(3'h6, 16'hffff);
		rd(3'h6, v);
		chk16("unmapped 6", 16'h0000, v);
		rd(3'h7, v);
		chk16("unmapped 7", 16'h0000, v);
		// Refused operation code and pairing leave state alone
		wr(`DAC_OFF_CMD, 16'h0005);
		rd(`DAC_OFF_ACC, v);
		chk16("acc refused", 16'h0123, v);
		rd(`DAC_OFF_STAT, v);
		chk16("stat refused", 16'h0010, v);
		chk16("flags refused", 16'h0fd5, flag_word);
		wr(`DAC_OFF_STAT, 16'h0010);
		rd(`DAC_OFF_STAT, v);
		chk16("stat clear", 16'h0000, v);
		wr(`DAC_OFF_DEST, 16'h4242);
		wr(`DAC_OFF_CMD, 16'h0064);
		rd(`DAC_OFF_DEST, v);
		chk16("dest refused", 16'h4242, v);
		rd(`DAC_OFF_STAT, v);
		chk16("stat pairing", 16'h0010, v);
		idle();
		// Reset in mid-run clears every register
		do_reset();
		chk16("flag_word reset", 16'h0000, flag_word);
		chk_op(DAC_OP_ADJ_ADD, last_op);
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), v);
			chk16("reset value", 16'h0000, v);
		end
		idle();
		test_done();
	end
endmodule : dac_alu_bench
`default_nettype wire
